/* File: core/psc_pkg.sv */
// constants, types and timing counts shared by the pseudo static ram controller
// assumes a single 25 MHz clock; every time below is turned into cycles of it
package psc_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int WORDS = 524288;
  localparam int ROWS = 2048;
  localparam int ROW_BITS = 11;
  localparam int CNT_W = 12;

  localparam int CLK_NS = 40;

  // least times round up, longest times round down, never below one cycle
  function automatic int cyc_ceil(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_floor(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int T_RC_NS = 115;
  localparam int T_RMW_NS = 165;
  localparam int T_CE_NS = 70;
  localparam int T_CEA_NS = 70;
  localparam int T_P_NS = 35;
  localparam int T_WP_NS = 25;
  localparam int T_RFD_NS = 40;
  localparam int T_FAP_MIN_NS = 30;
  localparam int T_FAP_MAX_NS = 8000;
  localparam int T_FC_NS = 130;
  localparam int T_FAS_NS = 8000;
  localparam int T_FRS_NS = 160;
  localparam int T_PAUSE_US = 100;
  localparam int T_REF_MS = 32;

  localparam int RC_CYC = cyc_ceil(T_RC_NS);
  localparam int RMW_CYC = cyc_ceil(T_RMW_NS);
  localparam int CE_CYC = cyc_ceil(T_CE_NS);
  localparam int CEA_CYC = cyc_ceil(T_CEA_NS);
  localparam int WP_CYC = cyc_ceil(T_WP_NS);
  localparam int WR_CYC = (CE_CYC > WP_CYC) ? CE_CYC : WP_CYC;
  localparam int PRE_CYC = (cyc_ceil(T_P_NS) > cyc_ceil(T_RFD_NS)) ?
                           cyc_ceil(T_P_NS) : cyc_ceil(T_RFD_NS);
  localparam int FAP_CYC = cyc_ceil(T_FAP_MIN_NS);
  localparam int FAP_MAX_CYC = cyc_floor(T_FAP_MAX_NS);
  localparam int FC_CYC = cyc_ceil(T_FC_NS);
  localparam int FAS_CYC = cyc_ceil(T_FAS_NS);
  localparam int FRS_CYC = cyc_ceil(T_FRS_NS);
  localparam int PAUSE_CYC = cyc_ceil(T_PAUSE_US * 1000);
  // one auto refresh per row slot keeps all rows inside the period
  localparam int REF_CYC = cyc_floor((T_REF_MS * 1000000) / ROWS);
  // three pin flops plus the agreement stage
  localparam int SYNC_LAT = 4;
  localparam int RD_CYC = CEA_CYC + SYNC_LAT;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_RMW
  } psc_op_e;

  typedef struct packed {
    psc_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } psc_req_s;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } psc_rsp_s;

  typedef struct packed {
    logic chip_enable_n;
    logic output_refresh_n;
    logic rw;
    logic dq_oe;
  } psc_ctl_s;

endpackage

/* File: core/psc_sync.sv */
// three-flop input synchroniser for pins that come from outside the clock domain
// assumes the pins settle long before the value is used; a change is taken
// only once the second and third stages agree
`timescale 1ns/1ps
module psc_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  initial begin
    if (W < 1) $error("psc_sync: width must be at least one");
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_o <= '0;
    end else if (en_i) begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // filters a bus caught mid-transition
      if (s2_q == s3_q) begin
        q_o <= s3_q;
      end
    end
  end

endmodule

/* File: core/psc_ctrl.sv */
// controller that drives a pseudo static ram through its pins
// assumes a 25 MHz clock, user logic on the same clock, and the ram on the pins
// What this block does
// - address is latched at chip enable fall; hold it steady around it
// - write data is taken at first rise of rw or chip enable
// - successive random cycles start at least 115 ns apart
// - read then write in one chip enable cycle needs 165 ns
// - all 2048 rows must be refreshed within every 32 ms
// - auto refresh pulse lasts from 30 ns to 8,000 ns
// - auto refresh pulses start at least 130 ns apart
// - wait 40 ns after chip enable rises before a refresh pulse
// - after self refresh wait 160 ns before chip enable falls
// - hold chip enable high 100 us after power-up before any access
`timescale 1ns/1ps
module psc_ctrl #(
  parameter int PAUSE_CYC = psc_pkg::PAUSE_CYC,
  parameter int REF_CYC = psc_pkg::REF_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic EN_I,
  input wire logic REQ_VALID_I,
  input wire psc_pkg::psc_req_s REQ_I,
  output logic REQ_READY_O,
  output psc_pkg::psc_rsp_s RSP_O,
  input wire logic SLEEP_I,
  output logic SLEEP_ACK_O,
  output logic INIT_DONE_O,
  output logic CHIP_ENABLE_N_O,
  output logic OUTPUT_REFRESH_N_O,
  output logic RW_O,
  output logic [psc_pkg::ADDR_W-1:0] ADDRESS_BUS_O,
  output logic [psc_pkg::DATA_W-1:0] DATA_PINS_O,
  output logic DATA_PINS_OE_O,
  input wire logic [psc_pkg::DATA_W-1:0] DATA_PINS_I
);

  localparam logic [11:0] C_PAUSE = 12'(PAUSE_CYC);
  localparam logic [11:0] C_REF = 12'(REF_CYC);
  localparam logic [11:0] C_RD = 12'(psc_pkg::RD_CYC);
  localparam logic [11:0] C_WR = 12'(psc_pkg::WR_CYC);
  localparam logic [11:0] C_PRE = 12'(psc_pkg::PRE_CYC);
  localparam logic [11:0] C_FAP = 12'(psc_pkg::FAP_CYC);
  localparam logic [11:0] C_FAPMAX = 12'(psc_pkg::FAP_MAX_CYC);
  localparam logic [11:0] C_FC = 12'(psc_pkg::FC_CYC);
  localparam logic [11:0] C_FAS = 12'(psc_pkg::FAS_CYC);
  localparam logic [11:0] C_FRS = 12'(psc_pkg::FRS_CYC);
  localparam logic [11:0] C_RC = 12'(psc_pkg::RC_CYC);
  localparam logic [11:0] C_RMW = 12'(psc_pkg::RMW_CYC);
  localparam logic [11:0] C_SAT = 12'hFFF;

  initial begin
    if (PAUSE_CYC < 1 || PAUSE_CYC > 4095) $error("psc_ctrl: PAUSE_CYC out of range");
    if (REF_CYC < psc_pkg::FC_CYC + 16 || REF_CYC > 4095) $error("psc_ctrl: bad REF_CYC");
    if (psc_pkg::FC_CYC <= psc_pkg::FAP_CYC) $error("psc_ctrl: refresh gap too short");
  end

  typedef enum logic [3:0] {
    ST_INIT, ST_IDLE, ST_SETUP, ST_RD, ST_TURN, ST_WR, ST_WEND, ST_PRE,
    ST_RF, ST_RGAP, ST_SLF, ST_SEXIT
  } psc_state_e;

  logic rst_meta_q;
  logic rst_n_q;
  psc_state_e st_q;
  psc_state_e st_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [11:0] ref_cnt_q;
  logic pend_q;
  logic pend_d;
  logic accept;
  logic capture;
  psc_pkg::psc_op_e op_q;
  psc_pkg::psc_ctl_s ctl_q;
  psc_pkg::psc_ctl_s ctl_d;
  logic [psc_pkg::DATA_W-1:0] din;

  // reset enters asynchronously, leaves through two flops
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  psc_sync #(.W(psc_pkg::DATA_W)) u_din_sync (
    .clk_i(CLOCK_I),
    .rst_ni(rst_n_q),
    .en_i(EN_I),
    .d_i(DATA_PINS_I),
    .q_o(din)
  );

  function automatic logic [11:0] inc_sat(input logic [11:0] v);
    return (v == C_SAT) ? v : v + 12'h001;
  endfunction

  always_comb begin
    st_d = st_q;
    cnt_d = inc_sat(cnt_q);
    accept = 1'b0;
    capture = 1'b0;
    unique case (st_q)
      ST_INIT: begin
        if (cnt_q >= C_PAUSE - 12'h001) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (REQ_VALID_I && REQ_READY_O) begin
          accept = 1'b1;
          st_d = ST_SETUP;
        end else if (SLEEP_I) begin
          st_d = ST_SLF;
        end else if (pend_q) begin
          st_d = ST_RF;
        end
      end
      // address goes out a cycle ahead of the chip enable fall
      ST_SETUP: st_d = (op_q == psc_pkg::OP_WRITE) ? ST_WR : ST_RD;
      ST_RD: begin
        if (cnt_q == C_RD - 12'h001) begin
          capture = 1'b1;
          st_d = (op_q == psc_pkg::OP_RMW) ? ST_TURN : ST_PRE;
        end
      end
      // the ram lets go of the bus before we drive it
      ST_TURN: st_d = ST_WR;
      ST_WR: begin
        if (cnt_q == C_WR - 12'h001) begin
          st_d = ST_WEND;
        end
      end
      // rw rises while chip enable is still low, so rw's edge stores the data
      ST_WEND: st_d = ST_PRE;
      ST_PRE: begin
        if (cnt_q == C_PRE - 12'h001) begin
          st_d = ST_IDLE;
        end
      end
      ST_RF: begin
        if (cnt_q == C_FAP - 12'h001) begin
          st_d = ST_RGAP;
        end
      end
      ST_RGAP: begin
        if (cnt_q == C_FC - C_FAP - 12'h001) begin
          st_d = ST_IDLE;
        end
      end
      ST_SLF: begin
        // held at least the self refresh width even if sleep drops early
        if (!SLEEP_I && cnt_q >= C_FAS - 12'h001) begin
          st_d = ST_SEXIT;
        end
      end
      ST_SEXIT: begin
        if (cnt_q == C_FRS - 12'h001) begin
          st_d = ST_IDLE;
        end
      end
    endcase
    if (st_d != st_q) begin
      cnt_d = '0;
    end
  end

  always_comb begin
    ctl_d.chip_enable_n = !(st_d inside {ST_RD, ST_TURN, ST_WR, ST_WEND});
    // refresh pin only falls with chip enable high, or for a read
    ctl_d.output_refresh_n = !(st_d inside {ST_RD, ST_RF, ST_SLF});
    // output enable stays high through writes
    ctl_d.rw = (st_d != ST_WR);
    ctl_d.dq_oe = (st_d inside {ST_WR, ST_WEND});
  end

  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_INIT;
      cnt_q <= '0;
    end else if (EN_I) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // refresh slot timer; self refresh covers rows itself, so it restarts after
  assign pend_d = (ref_cnt_q == C_REF - 12'h001) || (st_q == ST_SEXIT && st_d == ST_IDLE) ||
                  (pend_q && !(st_q == ST_IDLE && st_d == ST_RF));

  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ref_cnt_q <= '0;
      pend_q <= 1'b0;
    end else if (EN_I) begin
      pend_q <= pend_d;
      if (st_q == ST_SLF || ref_cnt_q == C_REF - 12'h001) begin
        ref_cnt_q <= '0;
      end else begin
        ref_cnt_q <= ref_cnt_q + 12'h001;
      end
    end
  end

  // pins; address is left as is during refresh, the ram ignores it
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctl_q <= '{chip_enable_n: 1'b1, output_refresh_n: 1'b1, rw: 1'b1, dq_oe: 1'b0};
      op_q <= psc_pkg::OP_READ;
      ADDRESS_BUS_O <= '0;
      DATA_PINS_O <= '0;
    end else if (EN_I) begin
      ctl_q <= ctl_d;
      if (accept) begin
        op_q <= REQ_I.op;
        ADDRESS_BUS_O <= REQ_I.addr;
        DATA_PINS_O <= REQ_I.wdata;
      end
    end
  end

  assign CHIP_ENABLE_N_O = ctl_q.chip_enable_n;
  assign OUTPUT_REFRESH_N_O = ctl_q.output_refresh_n;
  assign RW_O = ctl_q.rw;
  assign DATA_PINS_OE_O = ctl_q.dq_oe;

  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      REQ_READY_O <= 1'b0;
      RSP_O <= '0;
      SLEEP_ACK_O <= 1'b0;
      INIT_DONE_O <= 1'b0;
    end else if (EN_I) begin
      REQ_READY_O <= (st_d == ST_IDLE) && !pend_d && !SLEEP_I;
      RSP_O.valid <= capture;
      if (capture) begin
        RSP_O.rdata <= din;
      end
      SLEEP_ACK_O <= (st_d == ST_SLF);
      INIT_DONE_O <= (st_d != ST_INIT);
    end
  end

  // checking helpers: cycle counts seen at the pins
  logic [11:0] h_cef_q;
  logic [11:0] h_olow_q;
  logic [11:0] h_oef_q;
  logic [11:0] h_up_q;
  logic [11:0] h_ref_q;
  logic h_ce_q;
  logic h_oe_q;

  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      h_cef_q <= C_SAT;
      h_olow_q <= '0;
      h_oef_q <= C_SAT;
      h_up_q <= '0;
      h_ref_q <= '0;
      h_ce_q <= 1'b1;
      h_oe_q <= 1'b1;
    end else if (EN_I) begin
      h_ce_q <= CHIP_ENABLE_N_O;
      h_oe_q <= OUTPUT_REFRESH_N_O;
      h_cef_q <= (h_ce_q && !CHIP_ENABLE_N_O) ? 12'h001 : inc_sat(h_cef_q);
      h_olow_q <= OUTPUT_REFRESH_N_O ? 12'h000 : inc_sat(h_olow_q);
      h_oef_q <= (h_oe_q && !OUTPUT_REFRESH_N_O && CHIP_ENABLE_N_O) ? 12'h001
                 : inc_sat(h_oef_q);
      h_up_q <= inc_sat(h_up_q);
      h_ref_q <= (!INIT_DONE_O || SLEEP_ACK_O || (h_oe_q && !OUTPUT_REFRESH_N_O
                 && CHIP_ENABLE_N_O)) ? 12'h000 : inc_sat(h_ref_q);
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!rst_n_q || !EN_I);

  sequence s_self_exit;
    $fell(SLEEP_ACK_O) && $rose(OUTPUT_REFRESH_N_O);
  endsequence

  sequence s_quiet_pins;
    (OUTPUT_REFRESH_N_O && CHIP_ENABLE_N_O) [*4];
  endsequence

  a_addr_stable: assert property (!CHIP_ENABLE_N_O |-> $stable(ADDRESS_BUS_O))
    else $error("address moved while chip enable low");
  a_drive_legal: assert property (DATA_PINS_OE_O |-> !CHIP_ENABLE_N_O &&
    OUTPUT_REFRESH_N_O && (!RW_O || !$past(RW_O)))
    else $error("data driven outside a write");
  a_write_data_hold: assert property ($rose(RW_O) |-> !CHIP_ENABLE_N_O &&
    DATA_PINS_OE_O && $stable(DATA_PINS_O))
    else $error("write data not held at rw rise");
  a_cycle_spacing: assert property ($fell(CHIP_ENABLE_N_O) |-> h_cef_q >= C_RC)
    else $error("access cycles too close");
  a_rmw_span: assert property ($rose(CHIP_ENABLE_N_O) && op_q == psc_pkg::OP_RMW
    |-> h_cef_q >= C_RMW)
    else $error("read modify write too short");
  a_refresh_strobe_n_width: assert property ($rose(OUTPUT_REFRESH_N_O) && CHIP_ENABLE_N_O |->
    (h_olow_q >= C_FAP && h_olow_q <= C_FAPMAX) || h_olow_q >= C_FAS)
    else $error("refresh pulse width illegal");
  a_refresh_strobe_n_after_ce: assert property ($fell(OUTPUT_REFRESH_N_O) && CHIP_ENABLE_N_O
    |-> $past(CHIP_ENABLE_N_O) && $past(DATA_PINS_OE_O) == 1'b0)
    else $error("refresh too soon after chip enable");
  a_refresh_strobe_n_spacing: assert property ($fell(OUTPUT_REFRESH_N_O) && CHIP_ENABLE_N_O
    |-> h_oef_q >= C_FC)
    else $error("auto refresh pulses too close");
  a_self_recover: assert property (s_self_exit |-> s_quiet_pins)
    else $error("chip enable too soon after self refresh");
  a_power_pause: assert property ($fell(CHIP_ENABLE_N_O) || $fell(OUTPUT_REFRESH_N_O)
    |-> h_up_q >= C_PAUSE && INIT_DONE_O)
    else $error("access before power-up pause");
  a_ref_interval: assert property (INIT_DONE_O && !SLEEP_ACK_O |->
    h_ref_q <= C_REF + 12'h020)
    else $error("refresh slot missed");

endmodule

/* File: sim/psc_ram_model.sv */
// behavioural pseudo static ram that stands on the far side of the controller
// assumes the bench resolves the shared data wire from the controller's drive enable alone
`timescale 1ns/1ps
module psc_ram_model #(
  parameter real PAUSE_NS = 800.0
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic rw_i,
  input wire logic [psc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [psc_pkg::DATA_W-1:0] din_i,
  output logic [psc_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output int viol_o,
  output int auto_o,
  output int self_o
);
  logic [psc_pkg::DATA_W-1:0] mem [0:psc_pkg::WORDS-1];
  logic [psc_pkg::ADDR_W-1:0] lat_q = '0;
  logic [psc_pkg::DATA_W-1:0] last_q = 8'h00;
  logic acc_ok = 1'b0;
  logic armed = 1'b0;
  logic rf_on = 1'b0;
  logic [10:0] row_q = 11'h000;
  realtime t_ce_fall = -1.0e9;
  realtime t_ce_rise = -1.0e9;
  realtime t_rf_fall = -1.0e9;
  realtime t_self_end = -1.0e9;
  realtime w;

  initial begin
    viol_o = 0;
    auto_o = 0;
    self_o = 0;
  end

  always @(negedge ce_n_i) begin
    lat_q = addr_i;
    if ($realtime < PAUSE_NS) viol_o++;
    if ($realtime - t_ce_fall < 115.0) viol_o++;
    if ($realtime - t_self_end < 160.0) viol_o++;
    t_ce_fall = $realtime;
    // data is not valid before the access time has run
    #70 acc_ok = !ce_n_i;
  end

  always @(posedge ce_n_i) begin
    acc_ok = 1'b0;
    t_ce_rise = $realtime;
  end

  always @(negedge rw_i or negedge ce_n_i) if (!ce_n_i && !rw_i) armed = 1'b1;

  // first rise of rw or chip enable ends the write, output enable plays no part
  always @(posedge rw_i or posedge ce_n_i) begin
    if (armed) mem[lat_q] = din_i;
    armed = 1'b0;
  end

  always @(posedge ce_n_i or posedge oe_n_i) last_q = mem[lat_q];

  // a released bus shows the inverse of the last byte, never a held value
  assign dq_oe_o = !ce_n_i && !oe_n_i && rw_i;
  assign dq_o = (dq_oe_o && acc_ok) ? mem[lat_q] : ~last_q;

  // chip enable may move in the same step as this pin; let both settle first
  always @(negedge oe_n_i) begin
    #1;
    if (ce_n_i && !oe_n_i) begin
      if ($realtime - 1.0 < PAUSE_NS) viol_o++;
      if ($realtime - 1.0 - t_ce_rise < 40.0) viol_o++;
      if ($realtime - 1.0 - t_rf_fall < 130.0) viol_o++;
      t_rf_fall = $realtime - 1.0;
      rf_on = 1'b1;
    end
  end

  // pulse width alone picks the refresh kind; address and rw are ignored
  always @(posedge oe_n_i) if (rf_on) begin
    rf_on = 1'b0;
    w = $realtime - t_rf_fall;
    if (w < 30.0) begin
      viol_o++;
    end else if (w < 8000.0) begin
      row_q = row_q + 11'h001;
      auto_o++;
    end else begin
      self_o++;
      t_self_end = $realtime;
    end
  end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the pseudo static ram controller
// assumes the ram model above and shortened pause and refresh counts
`timescale 1ns/1ps
module testbench;
  localparam int PAUSE = 20;
  localparam int REFC = 40;
  logic clk, rst_n, en, req_valid, req_ready, sleep, sleep_ack, init_done;
  logic ce_n, oe_n, rw, host_oe, ram_oe;
  psc_pkg::psc_req_s req;
  psc_pkg::psc_rsp_s rsp;
  logic [psc_pkg::ADDR_W-1:0] addr;
  logic [psc_pkg::DATA_W-1:0] hdata, ram_dq, pins;
  int viol, autos, selfs, n, base;
  int mismatches = 0;
  int checks = 0;
  logic [7:0] exp_mem [int];
  logic [18:0] alist [8];
  logic [21:0] snap;

  assign pins = host_oe ? hdata : ram_dq;

  psc_ctrl #(.PAUSE_CYC(PAUSE), .REF_CYC(REFC)) dut (
    .CLOCK_I(clk), .RSTN_I(rst_n), .EN_I(en), .REQ_VALID_I(req_valid), .REQ_I(req),
    .REQ_READY_O(req_ready), .RSP_O(rsp), .SLEEP_I(sleep), .SLEEP_ACK_O(sleep_ack),
    .INIT_DONE_O(init_done), .CHIP_ENABLE_N_O(ce_n), .OUTPUT_REFRESH_N_O(oe_n),
    .RW_O(rw), .ADDRESS_BUS_O(addr), .DATA_PINS_O(hdata), .DATA_PINS_OE_O(host_oe),
    .DATA_PINS_I(pins)
  );

  psc_ram_model #(.PAUSE_NS(PAUSE * 40.0)) ram (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .rw_i(rw), .addr_i(addr), .din_i(pins),
    .dq_o(ram_dq), .dq_oe_o(ram_oe), .viol_o(viol), .auto_o(autos), .self_o(selfs)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // both sides on the data wire at once would corrupt the byte
  always @(negedge clk) if (host_oe === 1'b1) cmp("bus contention", 0, ram_oe);

  task automatic close_out();
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic access(input psc_pkg::psc_op_e op, input logic [18:0] a, input logic [7:0] d);
    int k;
    logic [7:0] old;
    old = exp_mem.exists(a) ? exp_mem[a] : 8'h00;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a, wdata: d};
    k = 0;
    do begin @(negedge clk); k++; end while (req_ready !== 1'b1 && k < 200);
    cmp("ready wait", 1, k < 200);
    @(posedge clk);
    req_valid <= 1'b0;
    if (op != psc_pkg::OP_WRITE) begin
      k = 0;
      do begin @(negedge clk); k++; end while (rsp.valid !== 1'b1 && k < 30);
      // setup one cycle, chip enable low six: valid on the seventh edge, eighth low phase
      cmp("read latency", 8, k);
      cmp("read data", old, rsp.rdata);
    end
    if (op != psc_pkg::OP_READ) exp_mem[a] = d;
  endtask

  // the full run needs about 1400 cycles; ten times that means a hang
  initial begin
    #(15000 * 40);
    mismatches++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    en = 1'b1;
    req_valid = 1'b0;
    req = '0;
    sleep = 1'b0;
    void'($urandom(74118));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    while (init_done !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    cmp("pause length", 1, n >= PAUSE && n <= PAUSE + 4);
    cmp("pins idle after pause", 2'b11, {ce_n, oe_n});
    alist[0] = 19'h00000;
    alist[1] = 19'h7FFFF;
    for (int i = 2; i < 8; i++) alist[i] = 19'($urandom);
    foreach (alist[i]) access(psc_pkg::OP_WRITE, alist[i], 8'($urandom));
    foreach (alist[i]) access(psc_pkg::OP_READ, alist[i], 8'h00);
    for (int i = 0; i < 40; i++) begin
      // reads, writes and read-modify-writes back to back on a few addresses
      access(psc_pkg::psc_op_e'($urandom % 3), alist[$urandom % 8], 8'($urandom));
    end
    access(psc_pkg::OP_RMW, alist[1], 8'hA5);
    access(psc_pkg::OP_READ, alist[1], 8'h00);
    @(posedge clk);
    en <= 1'b0;
    @(negedge clk);
    snap = {ce_n, oe_n, rw, addr};
    repeat (5) @(negedge clk);
    cmp("frozen pins", snap, {ce_n, oe_n, rw, addr});
    @(posedge clk);
    en <= 1'b1;
    base = autos;
    repeat (10 * REFC) @(posedge clk);
    cmp("auto refresh count", 1, autos - base >= 9 && autos - base <= 11);
    @(posedge clk);
    sleep <= 1'b1;
    base = selfs;
    n = 0;
    while (sleep_ack !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    cmp("sleep ack", 1, sleep_ack);
    repeat (210) @(negedge clk);
    cmp("sleep pins", 3'b100, {ce_n, oe_n, req_ready});
    @(posedge clk);
    sleep <= 1'b0;
    repeat (20) @(negedge clk);
    cmp("self refresh count", 1, selfs - base);
    foreach (alist[i]) access(psc_pkg::OP_READ, alist[i], 8'h00);
    repeat (20) @(negedge clk);
    cmp("timing faults", 0, viol);
    close_out();
  end
endmodule
